// [src/aod_pkg.sv]
// shared constants for the over-range detector link: widths, reset values,
// register map of the gain controller, flag indices and cycle counts.
// assumes both ends run on one clock, sys_clk at 40 MHz.
package aod_pkg;

    // ==========================================================
    // sample path
    localparam int SAMPLE_W      = 12;
    localparam int MAG_W         = 8;
    localparam int PSEL_W        = 3;
    localparam int STRETCH_BASE  = 3;
    localparam int STRETCH_W     = 11;
    localparam int NUM_CORES     = 6;
    localparam int CORE_W        = 3;
    localparam int CNT_W         = 16;
    localparam int NUM_FLAGS     = 4;

    // flag order on the link
    localparam int FLAG_A_HIGH   = 0;
    localparam int FLAG_A_LOW    = 1;
    localparam int FLAG_B_HIGH   = 2;
    localparam int FLAG_B_LOW    = 3;

    // ==========================================================
    // cycle counts and the temperature step
    localparam int FG_CAL_CYCLES   = 1024;
    localparam int BG_SWAP_CYCLES  = 256;
    localparam int LOW_QUIET_CYCLES = 4000;
    localparam int TEMP_DELTA      = 8;

    // ==========================================================
    // reset values
    localparam logic [MAG_W-1:0]  HIGH_THR_RST = 8'he4;
    localparam logic [MAG_W-1:0]  LOW_THR_RST  = 8'h40;
    localparam logic [PSEL_W-1:0] PSEL_RST     = 3'h0;
    localparam logic [7:0]        GAIN_RST     = 8'h80;
    localparam logic [CORE_W-1:0] SPARE_RST    = 3'h5;

    // ==========================================================
    // controller registers (byte addresses)
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_THR    = 8'h04;
    localparam logic [7:0] REG_GAIN   = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0c;
    localparam logic [7:0] REG_MASK   = 8'h10;
    localparam logic [7:0] REG_LIVE   = 8'h14;

    // control bits
    localparam int CTRL_DUAL   = 0;
    localparam int CTRL_BG     = 1;
    localparam int CTRL_FGCAL  = 2;
    localparam int CTRL_AUTO   = 3;
    localparam int CTRL_INSEL  = 4;

    // threshold register fields
    localparam int THR_HIGH_LSB = 0;
    localparam int THR_LOW_LSB  = 8;
    localparam int THR_PSEL_LSB = 16;

    // status / mask bits
    localparam int ST_HIGH  = 0;
    localparam int ST_LOW   = 1;
    localparam int ST_CAL   = 2;
    localparam int ST_W     = 3;

    // live register: flags in [3:0], calibration busy here
    localparam int LIVE_CAL = 4;

endpackage : aod_pkg

// [src/aod_link_if.sv]
// link between the converter core and the gain-control logic.
// assumes both ends share sys_clk; no pin here is two-way.
interface aod_link_if;

    // ==========================================================
    // configuration, controller to converter
    logic                          dual_mode;
    logic                          single_input_sel;
    logic [aod_pkg::MAG_W-1:0]     high_threshold;
    logic [aod_pkg::MAG_W-1:0]     low_threshold;
    logic [aod_pkg::PSEL_W-1:0]    flag_pulse_length_sel;
    logic                          fg_cal_req;
    logic                          bg_cal_en;

    // ==========================================================
    // status and data, converter to controller
    logic                          chan_a_high_flag;
    logic                          chan_a_low_flag;
    logic                          chan_b_high_flag;
    logic                          chan_b_low_flag;
    logic                          cal_busy;
    logic                          sample_valid;
    logic [aod_pkg::SAMPLE_W-1:0]  sample_a;
    logic [aod_pkg::SAMPLE_W-1:0]  sample_b;

    modport dev (
        input  dual_mode, single_input_sel, high_threshold, low_threshold,
        input  flag_pulse_length_sel, fg_cal_req, bg_cal_en,
        output chan_a_high_flag, chan_a_low_flag, chan_b_high_flag, chan_b_low_flag,
        output cal_busy, sample_valid, sample_a, sample_b
    );

    modport host (
        output dual_mode, single_input_sel, high_threshold, low_threshold,
        output flag_pulse_length_sel, fg_cal_req, bg_cal_en,
        input  chan_a_high_flag, chan_a_low_flag, chan_b_high_flag, chan_b_low_flag,
        input  cal_busy, sample_valid, sample_a, sample_b
    );

endinterface : aod_link_if

// [src/aod_converter.sv]
// converter digital side: sample coding, core rotation, calibration and
// the stretched over-range flags.
// assumes the pin levels arrive as unsigned digitised values, asynchronous.
//
// How it works
// - dual: rising samples; single: rising plus falling
// - codes are signed two's complement, saturated
// - six cores interleave, spare swapped for calibration
// - foreground calibration stops sampling, background does not
// - controller reruns calibration on temperature change
// - magnitude compared against high and low thresholds
// - same thresholds for both channels
// - eight-bit magnitude, most negative saturates
// - flag set when magnitude reaches threshold
// - two flags per channel, high then low
// - receiver ORs channel flags in dual and single mode
// - flag held 2^(N+3) cycles after last event
// - high flag lowers system gain
// - long-quiet low flag raises system gain
module aod_converter #(
    parameter int FG_CAL_CYCLES  = aod_pkg::FG_CAL_CYCLES,
    parameter int BG_SWAP_CYCLES = aod_pkg::BG_SWAP_CYCLES
) (
    // clock and reset
    input  wire logic                          sys_clk,
    input  wire logic                          rstn,
    // pin levels at the rising edge
    input  wire logic [aod_pkg::SAMPLE_W-1:0]  input_a_pos,
    input  wire logic [aod_pkg::SAMPLE_W-1:0]  input_a_neg,
    input  wire logic [aod_pkg::SAMPLE_W-1:0]  input_b_pos,
    input  wire logic [aod_pkg::SAMPLE_W-1:0]  input_b_neg,
    // selected input at the falling edge, single mode only
    input  wire logic [aod_pkg::SAMPLE_W-1:0]  fall_pos,
    input  wire logic [aod_pkg::SAMPLE_W-1:0]  fall_neg,
    // core usage
    output logic      [aod_pkg::CORE_W-1:0]    core_a_id,
    output logic      [aod_pkg::CORE_W-1:0]    core_b_id,
    output logic      [aod_pkg::CORE_W-1:0]    spare_core_id,
    // link
    aod_link_if.dev                            lnk
);

    localparam int SW = aod_pkg::SAMPLE_W;
    localparam int CW = aod_pkg::CORE_W;
    localparam int KW = aod_pkg::STRETCH_W;
    localparam int NW = aod_pkg::CNT_W;

    typedef struct packed {
        logic [5:0][SW-1:0]                      sync1;
        logic [5:0][SW-1:0]                      sync2;
        logic                                    sample_valid;
        logic [SW-1:0]                           sample_a;
        logic [SW-1:0]                           sample_b;
        logic [aod_pkg::NUM_FLAGS-1:0]           flags;
        logic [aod_pkg::NUM_FLAGS-1:0][KW-1:0]   stretch;
        logic [CW-1:0]                           ptr;
        logic [CW-1:0]                           core_a;
        logic [CW-1:0]                           core_b;
        logic [CW-1:0]                           spare;
        logic [NW-1:0]                           swap_cnt;
        logic                                    cal_busy;
        logic [NW-1:0]                           cal_cnt;
    } aod_conv_state_t;

    aod_conv_state_t st;
    aod_conv_state_t next_st;

    // ==========================================================
    // helpers
    function automatic logic [SW-1:0] to_code(input logic [SW-1:0] pos,
                                              input logic [SW-1:0] neg);
        logic signed [SW:0] diff;
        diff = $signed({1'b0, pos}) - $signed({1'b0, neg});
        if (diff > $signed((SW+1)'(2047)))
            to_code = 12'h7ff;
        else if (diff < -$signed((SW+1)'(2048)))
            to_code = 12'h800;
        else
            to_code = diff[SW-1:0];
    endfunction : to_code

    function automatic logic [aod_pkg::MAG_W-1:0] magnitude(input logic [SW-1:0] code);
        logic [aod_pkg::MAG_W-1:0] top;
        top = code[SW-1 -: aod_pkg::MAG_W];
        if (top == 8'h80)
            magnitude = 8'h7f;
        else if (top[aod_pkg::MAG_W-1])
            magnitude = 8'(~top + 8'h01);
        else
            magnitude = top;
    endfunction : magnitude

    function automatic logic [CW-1:0] next_core(input logic [CW-1:0] c,
                                                input logic [CW-1:0] spare);
        logic [CW-1:0] n;
        n = (c == CW'(aod_pkg::NUM_CORES - 1)) ? '0 : CW'(c + 3'h1);
        if (n == spare)
            n = (n == CW'(aod_pkg::NUM_CORES - 1)) ? '0 : CW'(n + 3'h1);
        next_core = n;
    endfunction : next_core

    // ==========================================================
    // next state
    always_comb
    begin
        logic [KW-1:0]             len;
        logic [SW-1:0]             smp;
        logic [aod_pkg::MAG_W-1:0] thr;
        len = '0;
        smp = '0;
        thr = '0;
        next_st = st;

        // pin levels are asynchronous: two flops before use
        next_st.sync1 = {fall_neg, fall_pos, input_b_neg, input_b_pos, input_a_neg, input_a_pos};
        next_st.sync2 = st.sync1;

        // foreground calibration holds the converter offline
        if (st.cal_busy)
        begin
            if (st.cal_cnt == '0)
                next_st.cal_busy = 1'b0;
            else
                next_st.cal_cnt = NW'(st.cal_cnt - 16'h0001);
        end
        else if (lnk.fg_cal_req)
        begin
            next_st.cal_busy = 1'b1;
            next_st.cal_cnt  = NW'(FG_CAL_CYCLES - 1);
        end

        // background calibration keeps sampling; only the spare moves
        if (lnk.bg_cal_en && !st.cal_busy)
        begin
            if (st.swap_cnt == NW'(BG_SWAP_CYCLES - 1))
            begin
                next_st.swap_cnt = '0;
                next_st.spare = (st.spare == CW'(aod_pkg::NUM_CORES - 1)) ? '0
                              : CW'(st.spare + 3'h1);
            end
            else
            begin
                next_st.swap_cnt = NW'(st.swap_cnt + 16'h0001);
            end
        end
        else
        begin
            next_st.swap_cnt = '0;
        end

        if (next_st.cal_busy)
        begin
            next_st.sample_valid = 1'b0;
        end
        else
        begin
            next_st.sample_valid = 1'b1;
            if (lnk.dual_mode)
            begin
                next_st.sample_a = to_code(st.sync2[0], st.sync2[1]);
                next_st.sample_b = to_code(st.sync2[2], st.sync2[3]);
            end
            else
            begin
                // rising-edge half from the chosen input, falling half from the fall pins
                next_st.sample_a = lnk.single_input_sel ? to_code(st.sync2[2], st.sync2[3])
                                                        : to_code(st.sync2[0], st.sync2[1]);
                next_st.sample_b = to_code(st.sync2[4], st.sync2[5]);
            end
            // each sample goes to the next free core, the spare is skipped
            next_st.core_a = next_core(st.ptr, next_st.spare);
            next_st.core_b = next_core(next_st.core_a, next_st.spare);
            next_st.ptr    = next_st.core_b;
        end

        // over-range detection and pulse stretch
        len = KW'(11'h001 << (4'(lnk.flag_pulse_length_sel) + 4'(aod_pkg::STRETCH_BASE)));
        for (int i = 0; i < aod_pkg::NUM_FLAGS; i++)
        begin
            smp = (i < aod_pkg::FLAG_B_HIGH) ? st.sample_a : st.sample_b;
            thr = (i[0] == 1'b0) ? lnk.high_threshold : lnk.low_threshold;
            if (st.sample_valid && (magnitude(smp) >= thr))
                next_st.stretch[i] = len;
            else if (st.stretch[i] != '0)
                next_st.stretch[i] = KW'(st.stretch[i] - 11'h001);
            next_st.flags[i] = (next_st.stretch[i] != '0);
        end
    end

    // ==========================================================
    // state register
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            st       <= '0;
            st.spare <= aod_pkg::SPARE_RST;
            st.ptr   <= aod_pkg::SPARE_RST;
        end
        else
        begin
            st <= next_st;
        end
    end

    // ==========================================================
    // outputs straight from the state
    assign lnk.chan_a_high_flag = st.flags[aod_pkg::FLAG_A_HIGH];
    assign lnk.chan_a_low_flag  = st.flags[aod_pkg::FLAG_A_LOW];
    assign lnk.chan_b_high_flag = st.flags[aod_pkg::FLAG_B_HIGH];
    assign lnk.chan_b_low_flag  = st.flags[aod_pkg::FLAG_B_LOW];
    assign lnk.cal_busy         = st.cal_busy;
    assign lnk.sample_valid     = st.sample_valid;
    assign lnk.sample_a         = st.sample_a;
    assign lnk.sample_b         = st.sample_b;
    assign core_a_id            = st.core_a;
    assign core_b_id            = st.core_b;
    assign spare_core_id        = st.spare;

endmodule : aod_converter

// [src/aod_gain_ctrl.sv]
// gain-control logic that watches the over-range flags and programs the
// converter; software reaches it through a small register port.
// assumes temperature code arrives asynchronously; link shares sys_clk.
module aod_gain_ctrl #(
    parameter int LOW_QUIET_CYCLES = aod_pkg::LOW_QUIET_CYCLES,
    parameter int TEMP_DELTA       = aod_pkg::TEMP_DELTA
) (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    // register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    output logic             irq,
    // system side
    input  wire logic [7:0]  temp_code,
    output logic      [7:0]  gain_setting,
    // link
    aod_link_if.host         lnk
);

    localparam int NW = aod_pkg::CNT_W;
    localparam int SW = aod_pkg::ST_W;

    typedef struct packed {
        logic                        dual_mode;
        logic                        bg_en;
        logic                        auto_en;
        logic                        insel;
        logic [aod_pkg::MAG_W-1:0]   high_thr;
        logic [aod_pkg::MAG_W-1:0]   low_thr;
        logic [aod_pkg::PSEL_W-1:0]  psel;
        logic [7:0]                  gain;
        logic [SW-1:0]               status;
        logic [SW-1:0]               mask;
        logic [31:0]                 rdata;
        logic                        irq;
        logic                        fg_req;
        logic [7:0]                  temp_s1;
        logic [7:0]                  temp_s2;
        logic [7:0]                  temp_ref;
        logic [NW-1:0]               quiet_cnt;
        logic                        high_d;
        logic                        busy_d;
    } aod_ctrl_state_t;

    aod_ctrl_state_t st;
    aod_ctrl_state_t next_st;

    always_comb
    begin
        logic          high_any;
        logic          low_any;
        logic [8:0]    tdiff;
        logic [SW-1:0] ev;
        next_st = st;
        // channel A and B flags are ORed in both modes; in single mode they are halves of one stream
        high_any = lnk.chan_a_high_flag | lnk.chan_b_high_flag;
        low_any  = lnk.chan_a_low_flag | lnk.chan_b_low_flag;
        next_st.temp_s1 = temp_code;
        next_st.temp_s2 = st.temp_s1;
        tdiff = (st.temp_s2 >= st.temp_ref) ? {1'b0, st.temp_s2} - {1'b0, st.temp_ref}
                                            : {1'b0, st.temp_ref} - {1'b0, st.temp_s2};
        next_st.high_d = high_any;
        next_st.busy_d = lnk.cal_busy;
        next_st.fg_req = 1'b0;
        next_st.rdata  = '0;

        // automatic gain management
        if (st.auto_en)
        begin
            if (high_any && !st.high_d && st.gain != 8'h00)
                next_st.gain = 8'(st.gain - 8'h01);
            if (low_any || high_any)
                next_st.quiet_cnt = '0;
            else if (st.quiet_cnt == NW'(LOW_QUIET_CYCLES - 1))
            begin
                next_st.quiet_cnt = '0;
                if (st.gain != 8'hff)
                    next_st.gain = 8'(st.gain + 8'h01);
            end
            else
                next_st.quiet_cnt = NW'(st.quiet_cnt + 16'h0001);
            // recalibrate once the temperature has drifted
            if (!lnk.cal_busy && tdiff >= 9'(TEMP_DELTA))
            begin
                next_st.fg_req   = 1'b1;
                next_st.temp_ref = st.temp_s2;
            end
        end

        // register writes
        if (reg_wr)
        begin
            unique case (reg_addr)
                aod_pkg::REG_CTRL:
                begin
                    next_st.dual_mode = reg_wdata[aod_pkg::CTRL_DUAL];
                    next_st.bg_en     = reg_wdata[aod_pkg::CTRL_BG];
                    next_st.auto_en   = reg_wdata[aod_pkg::CTRL_AUTO];
                    next_st.insel     = reg_wdata[aod_pkg::CTRL_INSEL];
                    if (reg_wdata[aod_pkg::CTRL_FGCAL])
                    begin
                        next_st.fg_req   = 1'b1;
                        next_st.temp_ref = st.temp_s2;
                    end
                end
                aod_pkg::REG_THR:
                begin
                    next_st.high_thr = reg_wdata[aod_pkg::THR_HIGH_LSB +: aod_pkg::MAG_W];
                    next_st.low_thr  = reg_wdata[aod_pkg::THR_LOW_LSB +: aod_pkg::MAG_W];
                    next_st.psel     = reg_wdata[aod_pkg::THR_PSEL_LSB +: aod_pkg::PSEL_W];
                end
                aod_pkg::REG_GAIN:   next_st.gain = reg_wdata[7:0];
                aod_pkg::REG_STATUS: next_st.status = st.status & ~reg_wdata[SW-1:0];
                aod_pkg::REG_MASK:   next_st.mask = reg_wdata[SW-1:0];
                default:             next_st.gain = next_st.gain;
            endcase
        end

        // events are applied after the clear so that a set wins
        ev = '0;
        ev[aod_pkg::ST_HIGH] = high_any;
        ev[aod_pkg::ST_LOW]  = low_any;
        ev[aod_pkg::ST_CAL]  = st.busy_d && !lnk.cal_busy;
        next_st.status = next_st.status | ev;
        next_st.irq    = |(next_st.status & next_st.mask);

        // register reads, data in the following cycle only
        if (reg_rd)
        begin
            unique case (reg_addr)
                aod_pkg::REG_CTRL:   next_st.rdata = 32'({st.insel, st.auto_en, 1'b0,
                                                          st.bg_en, st.dual_mode});
                aod_pkg::REG_THR:    next_st.rdata = 32'({st.psel, st.low_thr, st.high_thr});
                aod_pkg::REG_GAIN:   next_st.rdata = 32'(st.gain);
                aod_pkg::REG_STATUS: next_st.rdata = 32'(st.status);
                aod_pkg::REG_MASK:   next_st.rdata = 32'(st.mask);
                aod_pkg::REG_LIVE:   next_st.rdata = 32'({lnk.cal_busy, lnk.chan_b_low_flag,
                                                          lnk.chan_b_high_flag,
                                                          lnk.chan_a_low_flag,
                                                          lnk.chan_a_high_flag});
                default:             next_st.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            st           <= '0;
            st.dual_mode <= 1'b1;
            st.high_thr  <= aod_pkg::HIGH_THR_RST;
            st.low_thr   <= aod_pkg::LOW_THR_RST;
            st.psel      <= aod_pkg::PSEL_RST;
            st.gain      <= aod_pkg::GAIN_RST;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign reg_rdata                 = st.rdata;
    assign irq                       = st.irq;
    assign gain_setting              = st.gain;
    assign lnk.dual_mode             = st.dual_mode;
    assign lnk.single_input_sel      = st.insel;
    assign lnk.high_threshold        = st.high_thr;
    assign lnk.low_threshold         = st.low_thr;
    assign lnk.flag_pulse_length_sel = st.psel;
    assign lnk.fg_cal_req            = st.fg_req;
    assign lnk.bg_cal_en             = st.bg_en;

endmodule : aod_gain_ctrl

// [tb/aod_link_monitor.sv]
// link checker: magnitude compare, flag stretch, calibration timing.
// assumes one clock; inputs are the link signals, instanced beside them.
module aod_link_monitor #(
    parameter int FGC = 16
) (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    // configuration
    input  wire logic [7:0]  high_threshold,
    input  wire logic [7:0]  low_threshold,
    input  wire logic [2:0]  flag_pulse_length_sel,
    input  wire logic        fg_cal_req,
    // status
    input  wire logic        chan_a_high_flag,
    input  wire logic        chan_a_low_flag,
    input  wire logic        chan_b_high_flag,
    input  wire logic        chan_b_low_flag,
    input  wire logic        cal_busy,
    input  wire logic        sample_valid,
    input  wire logic [11:0] sample_a,
    input  wire logic [11:0] sample_b
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int FGC_M1 = FGC - 1;
    logic [11:0] since_a;
    logic [7:0]  mag_a;
    logic [7:0]  mag_b;
    // ====================
    // helpers
    function automatic logic [7:0] mag(input logic [11:0] s);
        // most negative code has no positive twin
        if (s[11:4] == 8'h80)
            return 8'h7f;
        return s[11] ? 8'(-s[11:4]) : s[11:4];
    endfunction : mag
    assign mag_a = mag(sample_a);
    assign mag_b = mag(sample_b);
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            since_a <= 12'hfff;
        else if (sample_valid && mag_a >= high_threshold)
            since_a <= 12'h001;
        else if (since_a != 12'hfff)
            since_a <= since_a + 12'h001;
    end
    // ====================
    // properties
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);
    a_high_flag_a: assert property (
        sample_valid && mag_a >= high_threshold |=> chan_a_high_flag) else $error("a high missed");
    a_low_flag_a: assert property (
        sample_valid && mag_a >= low_threshold |=> chan_a_low_flag) else $error("a low missed");
    a_high_flag_b: assert property (
        sample_valid && mag_b >= high_threshold |=> chan_b_high_flag) else $error("b high missed");
    a_low_flag_b: assert property (
        sample_valid && mag_b >= low_threshold |=> chan_b_low_flag) else $error("b low missed");
    a_stretch_end: assert property (
        $fell(chan_a_high_flag) |-> since_a == (12'h008 << flag_pulse_length_sel) + 12'h001)
        else $error("stretch length wrong");
    a_reset_clear: assert property (
        $rose(rstn) |-> !(chan_a_high_flag || chan_a_low_flag || chan_b_high_flag
        || chan_b_low_flag || cal_busy)) else $error("flags set after reset");
    a_cal_start: assert property (
        fg_cal_req && !cal_busy |=> cal_busy && !sample_valid) else $error("cal start wrong");
    a_cal_length: assert property (
        $rose(cal_busy) |-> ##FGC_M1 cal_busy ##1 (!cal_busy && sample_valid))
        else $error("cal length wrong");
    cover property ($fell(chan_a_high_flag));
    cover property ($rose(cal_busy));
    cover property (chan_b_low_flag && !chan_b_high_flag);
endmodule : aod_link_monitor

// [tb/adc_overrange_detector_test.sv]
// bench: converter and gain controller joined, driven from the register port.
// assumes short calibration count below and a 40 MHz clock.
module adc_overrange_detector_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk = 1'b0;
    logic        rstn = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0]  temp = 8'h40;
    logic [11:0] pa = 12'h0, na = 12'h0, pb = 12'h0, nb = 12'h0, fp = 12'h0;
    logic [31:0] reg_rdata;
    logic        irq;
    logic [2:0]  ca, cb, cs;
    int          failures = 0, n_tests = 0, n;
    always #12.5 sys_clk = ~sys_clk;
    aod_link_if lnk ();
    aod_converter #(.FG_CAL_CYCLES(16), .BG_SWAP_CYCLES(8)) aod_converter_inst (
        .sys_clk(sys_clk), .rstn(rstn), .input_a_pos(pa), .input_a_neg(na),
        .input_b_pos(pb), .input_b_neg(nb), .fall_pos(fp), .fall_neg(na),
        .core_a_id(ca), .core_b_id(cb), .spare_core_id(cs), .lnk(lnk));
    aod_gain_ctrl #(.LOW_QUIET_CYCLES(20), .TEMP_DELTA(2)) aod_gain_ctrl_inst (
        .sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
        .temp_code(temp), .gain_setting(), .lnk(lnk));
    aod_link_monitor #(.FGC(16)) aod_link_monitor_inst (
        .sys_clk(sys_clk), .rstn(rstn), .high_threshold(lnk.high_threshold),
        .low_threshold(lnk.low_threshold), .flag_pulse_length_sel(lnk.flag_pulse_length_sel),
        .fg_cal_req(lnk.fg_cal_req), .chan_a_high_flag(lnk.chan_a_high_flag),
        .chan_a_low_flag(lnk.chan_a_low_flag), .chan_b_high_flag(lnk.chan_b_high_flag),
        .chan_b_low_flag(lnk.chan_b_low_flag), .cal_busy(lnk.cal_busy),
        .sample_valid(lnk.sample_valid), .sample_a(lnk.sample_a), .sample_b(lnk.sample_b));
    // ====================
    // tasks
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e)
        begin
            failures++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk("rdata", e, reg_rdata);
    endtask : rd
    task automatic cyc(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask : cyc
    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_sim
    // ====================
    // tests
    initial
    begin
        cyc(3);
        rstn <= 1'b1;
        cyc(1);
        chk("flags", 32'h0, {lnk.chan_b_low_flag, lnk.chan_b_high_flag,
            lnk.chan_a_low_flag, lnk.chan_a_high_flag});
        rd(8'h04, 32'h0000_40e4);
        rd(8'h18, 32'h0);
        $display("reset test done");
        wr(8'h04, 32'h0002_4050);
        for (int i = 0; i < 2; i++)
        begin
            @(posedge sys_clk);
            pa <= i ? 12'h500 : 12'h000;
            na <= i ? 12'h000 : 12'h800;
            pb <= i ? 12'h4f0 : 12'h000;
            nb <= i ? 12'h000 : 12'h4f0;
            cyc(4);
            chk("sample_a", i ? 32'h500 : 32'h800, lnk.sample_a);
            chk("sample_b", i ? 32'h4f0 : 32'hb10, lnk.sample_b);
            rd(8'h14, 32'hb);
        end
        @(posedge sys_clk);
        pa <= 12'h0;
        pb <= 12'h0;
        #1;
        for (n = 0; lnk.sample_a !== 12'h0 && n < 20; n++) cyc(1);
        for (n = 0; lnk.chan_a_high_flag === 1'b1 && n < 2000; n++) cyc(1);
        chk("stretch", 32, n);
        rd(8'h0c, 32'h3);
        chk("irq", 0, irq);
        wr(8'h10, 32'h1);
        cyc(1);
        chk("irq", 1, irq);
        wr(8'h0c, 32'h3);
        cyc(1);
        chk("irq", 0, irq);
        rd(8'h0c, 32'h0);
        $display("flag test done");
        wr(8'h00, 32'h7);
        for (n = 0; lnk.cal_busy !== 1'b1 && n < 5; n++) cyc(1);
        chk("valid", 0, lnk.sample_valid);
        for (n = 0; lnk.cal_busy === 1'b1 && n < 100; n++) cyc(1);
        chk("cal", 16, n);
        cyc(2);
        rd(8'h0c, 32'h4);
        for (int i = 0; i < 12; i++)
        begin
            cyc(1);
            chk("cores", 1, ca != cs && cb != cs && ca != cb);
        end
        $display("calibration test done");
        wr(8'h00, 32'h0);
        pa <= 12'h123;
        pb <= 12'h234;
        fp <= 12'h300;
        cyc(4);
        chk("single_a", 32'h123, lnk.sample_a);
        chk("single_b", 32'h300, lnk.sample_b);
        wr(8'h00, 32'h10);
        cyc(4);
        chk("single_sel", 32'h234, lnk.sample_a);
        $display("single mode test done");
        end_sim();
    end
    // tests need some 120 cycles; wide margin
    initial
    begin
        repeat (5000) @(posedge sys_clk);
        failures++;
        end_sim();
    end
endmodule : adc_overrange_detector_test
